// File: core/output_initial_level_pkg.sv
// Package for the compact timer output and counter-clear control.
// Assumes a single pclk domain and an APB slave with 32-bit data.
`default_nettype none
package output_initial_level_pkg;
    // ========================================
    // Register map
    localparam logic [11:0] ctrl_one_addr = 12'h000;
    localparam logic [11:0] ctrl_zero_addr = 12'h004;
    localparam logic [11:0] compare_a_addr = 12'h008;
    localparam logic [11:0] count_addr = 12'h00c;
    localparam logic [11:0] status_addr = 12'h010;
    localparam logic [11:0] int_enable_addr = 12'h014;
    localparam logic [11:0] int_clear_addr = 12'h018;
    // ========================================
    // Control one fields
    localparam int clear_sel_bit = 0;
    localparam int swap_bit = 1;
    localparam int invert_bit = 2;
    localparam int init_level_bit = 3;
    localparam int func_lo_bit = 4;
    localparam int func_hi_bit = 5;
    localparam int mode_lo_bit = 6;
    localparam int mode_hi_bit = 7;
    // Control zero fields
    localparam int compare_p_lsb = 0;
    localparam int compare_p_msb = 2;
    localparam int counter_on_bit = 3;
    // Status fields
    localparam int st_match_a = 0;
    localparam int st_match_p = 1;
    localparam int st_overflow = 2;
    localparam int status_width = 3;
    // ========================================
    // Widths and reset values
    localparam int count_width = 10;
    localparam int p_width = 3;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [9:0] count_max = 10'h3ff;
    localparam logic [31:0] bus_zero = 32'h0000_0000;
    // ========================================
    // Mode and output-function codes
    localparam logic [1:0] mode_compare = 2'h0;
    localparam logic [1:0] mode_pwm = 2'h2;
    localparam logic [1:0] mode_timer = 2'h3;
    localparam logic [1:0] func_keep = 2'h0;
    localparam logic [1:0] func_low = 2'h1;
    localparam logic [1:0] func_high = 2'h2;
    localparam logic [1:0] func_toggle = 2'h3;
    localparam logic [1:0] func_pwm_inactive = 2'h0;
    localparam logic [1:0] func_pwm_active = 2'h1;
    localparam logic [1:0] func_pwm_wave = 2'h2;
endpackage
`default_nettype wire

// File: core/output_initial_level_timer.sv
// Compact 10-bit timer with output-function and counter-clear control over APB.
// Assumes an APB master on pclk; the timer counts on every pclk while on.
// Reads and writes complete with pready in the second access cycle.
// Read data is loaded in the first access cycle and stands while pready is high.
// The pin output enable is active low: high only in timer/counter mode.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`default_nettype none
module output_initial_level_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic timer_output_pin,
    output logic timer_output_enable,
    output logic irq
);
    // ========================================
    // State
    logic [7:0] timer_control_one, next_timer_control_one;
    logic [2:0] compare_p_value, next_compare_p_value;
    logic counter_on, next_counter_on;
    logic [9:0] compare_a_value, next_compare_a_value;
    logic [9:0] count, next_count;
    logic out_level, next_out_level;
    logic [2:0] status, next_status;
    logic [2:0] int_enable, next_int_enable;
    logic [31:0] next_prdata;

    // ========================================
    // Decode
    logic wr, rd, mapped, on_rise;
    logic access, wait_done, next_wait_done;
    logic [1:0] mode, func;
    logic init_level, invert, swap, clear_sel;
    logic match_a, match_p, at_max, clear_cnt, p_zero;
    logic [9:0] p_full, period_end, duty;
    logic pwm_dir, pwm_level, raw_out;

    // Writes land and pready rises in the second access cycle.
    assign access = psel & penable;
    assign next_wait_done = access & ~wait_done;
    assign pready = wait_done;
    assign wr = access & wait_done & pwrite;
    assign rd = access & ~wait_done & ~pwrite;
    assign mode = {timer_control_one[output_initial_level_pkg::mode_hi_bit],
                   timer_control_one[output_initial_level_pkg::mode_lo_bit]};
    assign func = {timer_control_one[output_initial_level_pkg::func_hi_bit],
                   timer_control_one[output_initial_level_pkg::func_lo_bit]};
    assign init_level = timer_control_one[output_initial_level_pkg::init_level_bit];
    assign invert = timer_control_one[output_initial_level_pkg::invert_bit];
    assign swap = timer_control_one[output_initial_level_pkg::swap_bit];
    assign clear_sel = timer_control_one[output_initial_level_pkg::clear_sel_bit];
    assign on_rise = next_counter_on & ~counter_on;

    always_comb begin
        mapped = 1'b1;
        unique case (paddr)
            output_initial_level_pkg::ctrl_one_addr, output_initial_level_pkg::ctrl_zero_addr, output_initial_level_pkg::compare_a_addr,
            output_initial_level_pkg::count_addr, output_initial_level_pkg::status_addr, output_initial_level_pkg::int_enable_addr,
            output_initial_level_pkg::int_clear_addr: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = access & wait_done & ~mapped;

    // ========================================
    // Comparators
    // P sees only the top three count bits, so its matches fall on multiples of 128.
    assign p_zero = (compare_p_value == 3'h0);
    assign p_full = {compare_p_value, 7'h00};
    assign match_a = counter_on & (count == compare_a_value);
    assign match_p = counter_on & ~p_zero
        & (count[9:7] == compare_p_value) & (count[6:0] == 7'h00);
    assign at_max = counter_on & (count == output_initial_level_pkg::count_max);

    // In PWM mode the period register picks the restart point.
    assign period_end = swap ? compare_a_value : p_full;
    assign duty = swap ? p_full : compare_a_value;

    always_comb begin
        if (mode == output_initial_level_pkg::mode_pwm) begin
            if (swap) begin
                clear_cnt = match_a | at_max;
            end else begin
                clear_cnt = match_p | (p_zero & at_max);
            end
        end else if (clear_sel) begin
            clear_cnt = match_a | at_max;
        end else begin
            clear_cnt = match_p | (p_zero & at_max);
        end
    end

    // Duty at or above the period gives a full active cycle.
    assign pwm_dir = (count < duty) | (duty >= period_end && period_end != 10'h000);
    assign pwm_level = pwm_dir ? init_level : ~init_level;

    // ========================================
    // Output pin
    // The held level loads the initial level on every start and follows A matches only in compare mode; PWM drives a forced or waveform level.
    always_comb begin
        next_out_level = out_level;
        if (on_rise) begin
            next_out_level = init_level;
        end else if (mode == output_initial_level_pkg::mode_compare && match_a) begin
            unique case (func)
                output_initial_level_pkg::func_keep: next_out_level = out_level;
                output_initial_level_pkg::func_low: next_out_level = 1'b0;
                output_initial_level_pkg::func_high: next_out_level = 1'b1;
                output_initial_level_pkg::func_toggle: next_out_level = ~out_level;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_level <= 1'b0;
        end else begin
            out_level <= next_out_level;
        end
    end

    always_comb begin
        raw_out = out_level;
        if (mode == output_initial_level_pkg::mode_pwm) begin
            unique case (func)
                output_initial_level_pkg::func_pwm_inactive: raw_out = ~init_level;
                output_initial_level_pkg::func_pwm_active: raw_out = init_level;
                output_initial_level_pkg::func_pwm_wave: raw_out = pwm_level;
                default: raw_out = ~init_level;
            endcase
        end
    end

    // Pin is released in timer/counter mode and driven otherwise.
    assign timer_output_enable = (mode == output_initial_level_pkg::mode_timer);
    assign timer_output_pin = (mode == output_initial_level_pkg::mode_timer) ? 1'b0
        : (raw_out ^ invert);

    // ========================================
    // Counter
    // Counting halts while the timer is off; a restart always begins at zero.
    always_comb begin
        next_count = count;
        if (on_rise) begin
            next_count = 10'h000;
        end else if (counter_on) begin
            next_count = clear_cnt ? 10'h000 : count + 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 10'h000;
        end else begin
            count <= next_count;
        end
    end

    // ========================================
    // Bus wait state
    // A read word is loaded in the first access cycle and stands in the second,
    // where pready is high, so the master takes it at the completing edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_done <= 1'b0;
        end else begin
            wait_done <= next_wait_done;
        end
    end

    // ========================================
    // Write strobes
    // Every register write is qualified by pready, so it lands on the completing edge.
    logic wr_ctrl_one, wr_ctrl_zero, wr_compare_a, wr_int_enable, wr_int_clear;
    assign wr_ctrl_one = wr & (paddr == output_initial_level_pkg::ctrl_one_addr);
    assign wr_ctrl_zero = wr & (paddr == output_initial_level_pkg::ctrl_zero_addr);
    assign wr_compare_a = wr & (paddr == output_initial_level_pkg::compare_a_addr);
    assign wr_int_enable = wr & (paddr == output_initial_level_pkg::int_enable_addr);
    assign wr_int_clear = wr & (paddr == output_initial_level_pkg::int_clear_addr);

    // ========================================
    // Control one register
    always_comb begin
        next_timer_control_one = timer_control_one;
        if (wr_ctrl_one) begin
            next_timer_control_one = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_one <= output_initial_level_pkg::ctrl_reset;
        end else begin
            timer_control_one <= next_timer_control_one;
        end
    end

    // ========================================
    // Compare and counter-on registers
    // A counter-on write that turns the counter on restarts the count and loads the initial pin level.
    always_comb begin
        next_compare_p_value = compare_p_value;
        next_counter_on = counter_on;
        next_compare_a_value = compare_a_value;
        if (wr_ctrl_zero) begin
            next_compare_p_value = pwdata[output_initial_level_pkg::compare_p_msb:output_initial_level_pkg::compare_p_lsb];
            next_counter_on = pwdata[output_initial_level_pkg::counter_on_bit];
        end
        if (wr_compare_a) begin
            next_compare_a_value = pwdata[9:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_p_value <= 3'h0;
            counter_on <= 1'b0;
            compare_a_value <= 10'h000;
        end else begin
            compare_p_value <= next_compare_p_value;
            counter_on <= next_counter_on;
            compare_a_value <= next_compare_a_value;
        end
    end

    // ========================================
    // Interrupt enable
    // Enable bits share the layout of the status flags.
    always_comb begin
        next_int_enable = int_enable;
        if (wr_int_enable) begin
            next_int_enable = pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_enable <= 3'h0;
        end else begin
            int_enable <= next_int_enable;
        end
    end

    // ========================================
    // Status flags
    // Each flag is sticky; an event wins over a clear in the same cycle.
    // The P match flag is not raised while A clears the counter outside PWM mode.
    logic [2:0] status_event;
    assign status_event[output_initial_level_pkg::st_match_a] = match_a;
    assign status_event[output_initial_level_pkg::st_match_p] = match_p
        & ((mode == output_initial_level_pkg::mode_pwm) | ~clear_sel);
    assign status_event[output_initial_level_pkg::st_overflow] = at_max;
    for (genvar b = 0; b < output_initial_level_pkg::status_width; b++) begin : g_status
        assign next_status[b] = status_event[b] | (status[b] & ~(wr_int_clear & pwdata[b]));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 3'h0;
        end else begin
            status <= next_status;
        end
    end

    // ========================================
    // Interrupt output
    // The request is registered from the next flag and enable values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & next_int_enable);
        end
    end

    // ========================================
    // Read data
    always_comb begin
        next_prdata = output_initial_level_pkg::bus_zero;
        if (rd) begin
            unique case (paddr)
                output_initial_level_pkg::ctrl_one_addr: begin
                    next_prdata[7:0] = timer_control_one;
                end
                output_initial_level_pkg::ctrl_zero_addr: begin
                    next_prdata[output_initial_level_pkg::compare_p_msb:output_initial_level_pkg::compare_p_lsb] =
                        compare_p_value;
                    next_prdata[output_initial_level_pkg::counter_on_bit] = counter_on;
                end
                output_initial_level_pkg::compare_a_addr: begin
                    next_prdata[9:0] = compare_a_value;
                end
                output_initial_level_pkg::count_addr: begin
                    next_prdata[9:0] = count;
                end
                output_initial_level_pkg::status_addr: begin
                    next_prdata[2:0] = status;
                end
                output_initial_level_pkg::int_enable_addr: begin
                    next_prdata[2:0] = int_enable;
                end
                default: next_prdata = output_initial_level_pkg::bus_zero;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= output_initial_level_pkg::bus_zero;
        end else begin
            prdata <= next_prdata;
        end
    end
endmodule
`default_nettype wire

// File: verification/output_initial_level_timer_chk.sv
// Port checker for the compact timer output block.
// Assumes it is bound into output_initial_level_timer and sees only its ports.
`default_nettype none
module output_initial_level_timer_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_output_pin,
    input wire logic timer_output_enable,
    input wire logic irq
);
    // ========================================
    // Shadow of control one and the counter-on bit.
    logic [7:0] one;
    logic on;
    logic wr;
    assign wr = psel && penable && pwrite && pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            one <= 8'h00;
            on <= 1'b0;
        end else begin
            if (wr && paddr == output_initial_level_pkg::ctrl_one_addr) begin
                one <= pwdata[7:0];
            end
            if (wr && paddr == output_initial_level_pkg::ctrl_zero_addr) begin
                on <= pwdata[3];
            end
        end
    end
    // ========================================
    // Assertions.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_slverr_unmapped:
        assert property (psel && penable && pready && paddr > 12'h018 |-> pslverr)
        else $error("no error flag on unmapped access");
    a_unmapped_reads_zero:
        assert property (psel && penable && !pwrite && paddr > 12'h018 |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_timer_released:
        assert property (one[7:6] == 2'h3 |-> timer_output_enable && !timer_output_pin)
        else $error("pin driven in timer mode");
    a_pin_driven:
        assert property (one[7:6] == 2'h0 || one[7:6] == 2'h2 |-> !timer_output_enable)
        else $error("pin released in output mode");
    a_on_rise_initial:
        assert property ($rose(on) && one[7:6] == 2'h0 |-> timer_output_pin == (one[3] ^ one[2]))
        else $error("pin not at initial level after start");
    a_pwm_forced:
        assert property (one[7:6] == 2'h2 && one[5:4] != 2'h2 |->
            timer_output_pin == ((one[5:4] == 2'h1 ? one[3] : ~one[3]) ^ one[2]))
        else $error("forced pwm level wrong");
    a_keep_stable:
        assert property (one[7:4] == 4'h0 && $stable(one) && !$rose(on) |->
            $stable(timer_output_pin))
        else $error("pin moved with no change code");
    a_irq_masked:
        assert property (wr && paddr == output_initial_level_pkg::int_enable_addr && pwdata[2:0] == 3'h0
            |-> ##2 !irq)
        else $error("irq high with all sources masked");
endmodule
bind output_initial_level_timer output_initial_level_timer_chk u_output_initial_level_timer_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_output_pin,
    .timer_output_enable, .irq);
`default_nettype wire

// File: verification/output_initial_level_timer_tb.sv
// Self-checking bench for the compact timer output block over APB.
// Assumes output_initial_level_pkg, output_initial_level_timer and the checker are compiled first.
`default_nettype none
module output_initial_level_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, pin, oe, irq, err;
    int mismatches = 0, tests_run = 0, i;
    always #12.5 pclk = ~pclk;
    output_initial_level_timer u_output_initial_level_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .timer_output_pin(pin),
        .timer_output_enable(oe), .irq);
    // ========================================
    // Bus, compare and closing tasks.
    task automatic x(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic w8(input int n);
        repeat (n) @(negedge pclk);
    endtask
    task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic pk(input logic e);
        @(negedge pclk);
        ck("pin", {31'h0, e}, {31'h0, pin});
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        conclude();
    end
    // ========================================
    // Test sequence.
    initial begin
        logic [2:0] e;
        logic [31:0] h;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 3; i++) begin
            x(1'b0, 12'(4 * i), 32'h0);
            ck("reset", 32'h0, q);
        end
        x(1'b1, 12'h000, 32'h3c);
        x(1'b0, 12'h000, 32'h0);
        ck("ctrl_one", 32'h3c, q);
        x(1'b1, 12'h01c, 32'hffff_ffff);
        x(1'b0, 12'h01c, 32'h0);
        ck("slverr", 32'h1, {31'h0, err});
        ck("unmapped", 32'h0, q);
        $display("test registers done");
        x(1'b1, 12'h008, 32'h5);
        for (i = 0; i < 16; i++) begin
            x(1'b1, 12'h000, {24'h0, 2'b00, i[1:0], i[2], i[3], 2'b00});
            x(1'b1, 12'h004, 32'h8);
            pk(i[2] ^ i[3]);
            w8(10);
            pk((i[1:0] == 2'h0 ? i[2] : i[1:0] == 2'h3 ? ~i[2] : i[1]) ^ i[3]);
            x(1'b1, 12'h004, 32'h0);
        end
        ck("oe", 32'h0, {31'h0, oe});
        $display("test compare done");
        for (i = 0; i < 2; i++) begin
            x(1'b1, 12'h000, i ? 32'ha6 : 32'ha8);
            x(1'b1, 12'h008, i ? 32'hc8 : 32'h20);
            x(1'b1, 12'h004, 32'h9);
            e = i ? 3'b101 : 3'b011;
            w8(18);
            pk(e[0]);
            w8(129);
            pk(e[1]);
            w8(64);
            pk(e[2]);
            x(1'b1, 12'h004, 32'h0);
        end
        for (i = 0; i < 3; i++) begin
            x(1'b1, 12'h000, i == 0 ? 32'h98 : i == 1 ? 32'h88 : 32'h8c);
            pk(i != 1);
        end
        x(1'b1, 12'h000, 32'hfc);
        pk(1'b0);
        ck("oe", 32'h1, {31'h0, oe});
        $display("test pwm done");
        x(1'b1, 12'h008, 32'ha);
        for (i = 0; i < 3; i++) begin
            x(1'b1, 12'h000, i == 0 ? 32'h01 : 32'h00);
            x(1'b1, 12'h004, i == 2 ? 32'h9 : 32'h8);
            w8(140);
            x(1'b1, 12'h004, 32'h0);
            x(1'b0, 12'h00c, 32'h0);
            h = q;
            ck("count", 32'h1, {31'h0, i == 1 ? q > 32'd100 : q < 32'd30});
            w8(5);
            x(1'b0, 12'h00c, 32'h0);
            ck("held", h, q);
        end
        $display("test clear done");
        x(1'b0, 12'h010, 32'h0);
        ck("status", 32'h3, q);
        x(1'b1, 12'h014, 32'h1);
        w8(3);
        ck("irq", 32'h1, {31'h0, irq});
        x(1'b1, 12'h014, 32'h0);
        w8(3);
        ck("irq", 32'h0, {31'h0, irq});
        x(1'b1, 12'h004, 32'h8);
        w8(1030);
        x(1'b1, 12'h004, 32'h0);
        x(1'b0, 12'h010, 32'h0);
        ck("overflow", 32'h7, q);
        x(1'b1, 12'h014, 32'h7);
        x(1'b1, 12'h018, 32'h7);
        x(1'b0, 12'h010, 32'h0);
        ck("status", 32'h0, q);
        ck("irq", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        conclude();
    end
endmodule
`default_nettype wire
